// *** rtl/did_pkg.sv ***
/*
 Constants and carrier types for the instruction decode and issue-timing block.
 Assumes a 24-bit program word and a single core instruction clock.
*/
package did_pkg;
    localparam int WORD_W = 24;
    localparam int OPC_W = 8;
    localparam int OPC_LSB = 16;
    // opcode values; the field layout below is a plain encoding for this core
    localparam logic [7:0] OPC_NOP2 = 8'h00;
    localparam logic [7:0] OPC_JUMP_ABS = 8'h04;
    localparam logic [7:0] OPC_CALL_ABS = 8'h02;
    localparam logic [7:0] OPC_DO_LOOP = 8'h08;
    localparam logic [7:0] OPC_BRANCH_ALWAYS = 8'h37;
    localparam logic [7:0] OPC_BRANCH_COND_LO = 8'h30;
    localparam logic [7:0] OPC_BRANCH_COND_HI = 8'h3F;
    localparam logic [7:0] OPC_CALL_IND = 8'h01;
    localparam logic [7:0] OPC_RETURN = 8'h06;
    localparam logic [7:0] OPC_INT_RETURN = 8'h05;
    localparam logic [7:0] OPC_TBL_LO = 8'hBA;
    localparam logic [7:0] OPC_TBL_HI = 8'hBB;
    localparam logic [7:0] OPC_SKIP_LO = 8'hA6;
    localparam logic [7:0] OPC_SKIP_HI = 8'hA7;
    localparam logic [7:0] OPC_MOVD = 8'hBE;
    localparam logic [7:0] OPC_BIT_LO = 8'hA0;
    localparam logic [7:0] OPC_BIT_HI = 8'hAF;
    localparam logic [7:0] OPC_LIT_LO = 8'hB0;
    localparam logic [7:0] OPC_LIT_HI = 8'hB3;
    localparam logic [7:0] OPC_FILE_LO = 8'hB4;
    localparam logic [7:0] OPC_FILE_HI = 8'hB9;
    localparam logic [7:0] OPC_DSP_LO = 8'hC0;
    localparam logic [7:0] OPC_MAC_HI = 8'hC7;
    localparam logic [7:0] OPC_DSP_HI = 8'hCF;
    localparam logic [7:0] OPC_CTRL_LO = 8'h00;
    localparam logic [7:0] OPC_CTRL_HI = 8'h3F;
    localparam logic [3:0] W_ZERO = 4'h0;
    localparam logic [3:0] W_ACC_WB = 4'hD;
    localparam logic [3:0] W_MUL_BASE = 4'h4;
    localparam logic [1:0] CYC_ONE = 2'h1;
    localparam logic [1:0] CYC_TWO = 2'h2;
    localparam logic [1:0] CYC_THREE = 2'h3;

    typedef enum logic [2:0] {
        CLS_WORD_BYTE = 3'b000,
        CLS_BIT = 3'b001,
        CLS_LITERAL = 3'b010,
        CLS_DSP = 3'b011,
        CLS_CONTROL = 3'b100
    } did_class_t;

    typedef struct packed {
        logic [3:0] base_source_reg;
        logic [3:0] second_source_reg;
        logic [2:0] src_mode;
        logic [3:0] dest_reg;
        logic [2:0] dest_mode;
        logic [12:0] file_addr;
        logic to_working_reg_zero;
        logic [3:0] bit_pos;
        logic bit_indirect;
        logic [15:0] literal;
        logic dest_separate;
        logic acc_sel;
        logic [3:0] mul_a;
        logic [3:0] mul_b;
        logic [3:0] x_pref;
        logic [1:0] x_dest;
        logic [3:0] y_pref;
        logic [1:0] y_dest;
        logic [1:0] acc_writeback_dest;
        logic [5:0] shift_amt;
        logic shift_from_reg;
    } did_fields_t;

    typedef struct packed {
        logic valid;
        logic [7:0] opcode;
        did_class_t cls;
        logic is_nop;
        logic two_word;
        logic [1:0] cycles;
        logic mac;
        logic [23:0] ext_word;
    } did_issue_t;
endpackage

// *** rtl/did_field_split.sv ***
/*
 Operand field splitter: pure decode of one 24-bit word into operand fields.
 Assumes the class is already known from the opcode; no state.
*/
`timescale 1ns/100ps
module did_field_split (
    input wire logic [23:0] word,
    input wire did_pkg::did_class_t cls,
    input wire logic mac,
    output did_pkg::did_fields_t fields
);
    import did_pkg::*;

    always_comb begin
        fields = '0;
        case (cls)
            CLS_WORD_BYTE: begin
                fields.base_source_reg = word[14:11];
                fields.dest_reg = word[10:7];
                fields.dest_mode = word[6:4];
                fields.second_source_reg = word[3:0];
                fields.src_mode = word[15] ? 3'h1 : 3'h0;
            end
            CLS_BIT: begin
                fields.bit_indirect = word[15];
                fields.base_source_reg = word[14:11];
                fields.bit_pos = word[10:7];
                fields.second_source_reg = word[3:0];
                fields.src_mode = word[6:4];
                fields.file_addr = word[12:0];
            end
            CLS_LITERAL: begin
                fields.base_source_reg = word[14:11];
                fields.literal = {6'h00, word[9:0]};
                fields.dest_separate = word[15];
                fields.dest_reg = word[15] ? word[13:10] : word[14:11];
            end
            CLS_DSP: begin
                fields.acc_sel = word[15];
                if (mac) begin
                    case (word[14:12])
                        3'h0: {fields.mul_a, fields.mul_b} = {4'h4, 4'h5};
                        3'h1: {fields.mul_a, fields.mul_b} = {4'h4, 4'h6};
                        3'h2: {fields.mul_a, fields.mul_b} = {4'h4, 4'h7};
                        3'h4: {fields.mul_a, fields.mul_b} = {4'h5, 4'h6};
                        3'h5: {fields.mul_a, fields.mul_b} = {4'h5, 4'h7};
                        3'h6: {fields.mul_a, fields.mul_b} = {4'h6, 4'h7};
                        default: {fields.mul_a, fields.mul_b} = {4'h4, 4'h5};
                    endcase
                    fields.x_pref = word[11:8];
                    fields.x_dest = word[7:6];
                    fields.y_pref = word[5:2];
                    fields.y_dest = word[1:0];
                    fields.acc_writeback_dest = word[17:16];
                    fields.dest_reg = W_ACC_WB;
                end else begin
                    fields.second_source_reg = word[3:0];
                    fields.src_mode = word[6:4];
                    fields.shift_from_reg = word[14];
                    fields.shift_amt = word[14] ? {2'h0, word[10:7]} : word[12:7];
                end
            end
            default: begin
                fields.literal = word[15:0];
            end
        endcase
        if (cls == CLS_WORD_BYTE && word[23:16] >= OPC_FILE_LO
            && word[23:16] <= OPC_FILE_HI) begin
            fields.file_addr = word[12:0];
            fields.to_working_reg_zero = ~word[13];
            fields.dest_reg = word[13] ? W_ZERO : W_ZERO;
        end
    end
endmodule

// *** rtl/did_decode.sv ***
/*
 Instruction decode and issue timing: classifies each program word, splits
 operands, handles two-word pairs and inserts no-operation cycles.
 Assumes program memory presents one word per cycle with a valid flag and
 holds the word while FETCH_STALL is high; branch/skip outcomes arrive
 from the execute stage on the same clock.
*/
`timescale 1ns/100ps
module did_decode (
    input wire logic CLOCK,
    input wire logic RST,
    input wire logic [23:0] PM_WORD,
    input wire logic PM_VALID,
    input wire logic COND_TRUE,
    input wire logic SKIP_TAKEN,
    input wire logic TBL_LONG,
    output did_pkg::did_issue_t ISSUE,
    output did_pkg::did_fields_t FIELDS,
    output logic FETCH_STALL,
    output logic BUBBLE
);
    import did_pkg::*;

    typedef enum logic [1:0] {
        ST_FETCH = 2'b00,
        ST_EXT = 2'b01,
        ST_WAIT = 2'b10
    } did_state_t;

    did_state_t state_r, state_nxt;
    logic [1:0] extra_r, extra_nxt;
    logic skip_pend_r, skip_pend_nxt;
    did_issue_t issue_r, issue_nxt;
    did_fields_t fields_r, fields_nxt;
    logic stall_r, stall_nxt;
    logic bubble_r, bubble_nxt;

    logic [7:0] opc;
    did_class_t cls;
    logic two_word, is_mac, is_ext, is_change, is_fixed, is_skip, is_movd;
    did_fields_t split;

    assign opc = PM_WORD[OPC_LSB +: OPC_W];
    // upper byte zero marks an extension word
    assign is_ext = (opc == OPC_NOP2);
    assign two_word = (opc == OPC_JUMP_ABS) || (opc == OPC_CALL_ABS) || (opc == OPC_DO_LOOP);
    assign is_mac = (opc >= OPC_DSP_LO) && (opc <= OPC_MAC_HI);
    assign is_fixed = (opc == OPC_BRANCH_ALWAYS) || (opc == OPC_CALL_IND)
        || (opc == OPC_RETURN) || (opc == OPC_INT_RETURN)
        || (opc >= OPC_TBL_LO && opc <= OPC_TBL_HI);
    assign is_change = (opc >= OPC_BRANCH_COND_LO) && (opc <= OPC_BRANCH_COND_HI)
        && (opc != OPC_BRANCH_ALWAYS);
    assign is_skip = (opc >= OPC_SKIP_LO) && (opc <= OPC_SKIP_HI);
    assign is_movd = (opc == OPC_MOVD);

    always_comb begin
        if (opc >= OPC_DSP_LO && opc <= OPC_DSP_HI) begin
            cls = CLS_DSP;
        end else if (opc >= OPC_BIT_LO && opc <= OPC_BIT_HI && !is_skip) begin
            cls = CLS_BIT;
        end else if (opc >= OPC_LIT_LO && opc <= OPC_LIT_HI) begin
            cls = CLS_LITERAL;
        end else if (opc <= OPC_CTRL_HI || is_skip || (opc >= OPC_TBL_LO && opc <= OPC_TBL_HI)) begin
            cls = CLS_CONTROL;
        end else begin
            cls = CLS_WORD_BYTE;
        end
    end

    did_field_split u_split (
        .word(PM_WORD),
        .cls(cls),
        .mac(is_mac),
        .fields(split)
    );

    always_comb begin
        state_nxt = state_r;
        extra_nxt = extra_r;
        skip_pend_nxt = skip_pend_r;
        issue_nxt = issue_r;
        issue_nxt.valid = 1'b0;
        fields_nxt = fields_r;
        stall_nxt = 1'b0;
        bubble_nxt = 1'b0;
        case (state_r)
            ST_FETCH: begin
                if (PM_VALID) begin
                    issue_nxt.opcode = opc;
                    issue_nxt.cls = cls;
                    issue_nxt.mac = is_mac;
                    issue_nxt.two_word = two_word;
                    issue_nxt.ext_word = '0;
                    issue_nxt.is_nop = is_ext || skip_pend_r;
                    fields_nxt = split;
                    issue_nxt.cycles = CYC_ONE;
                    extra_nxt = 2'h0;
                    if (skip_pend_r) begin
                        // skipped word: a two-word victim takes one more cycle for its second word, with no bubble
                        issue_nxt.valid = 1'b1;
                        issue_nxt.cycles = two_word ? CYC_TWO : CYC_ONE;
                        skip_pend_nxt = 1'b0;
                        if (two_word) begin
                            state_nxt = ST_EXT;
                            issue_nxt.valid = 1'b0;
                        end
                    end else if (is_ext) begin
                        // lone extension word is a plain NOP
                        issue_nxt.valid = 1'b1;
                        fields_nxt = '0;
                    end else if (two_word) begin
                        issue_nxt.cycles = CYC_TWO;
                        state_nxt = ST_EXT;
                    end else begin
                        issue_nxt.valid = 1'b1;
                        if (is_fixed) begin
                            issue_nxt.cycles = TBL_LONG ? CYC_THREE : CYC_TWO;
                            extra_nxt = TBL_LONG ? 2'h2 : 2'h1;
                        end else if (is_movd || (is_change && COND_TRUE)) begin
                            // double-word move or taken conditional branch costs one extra NOP
                            issue_nxt.cycles = CYC_TWO;
                            extra_nxt = 2'h1;
                        end else if (is_skip && SKIP_TAKEN) begin
                            issue_nxt.cycles = CYC_TWO;
                            skip_pend_nxt = 1'b1;
                        end
                        if (extra_nxt != 2'h0) begin
                            state_nxt = ST_WAIT;
                            stall_nxt = 1'b1;
                        end
                    end
                end
            end
            ST_EXT: begin
                if (PM_VALID) begin
                    // extension payload in low 16 bits
                    issue_nxt.ext_word = {8'h00, PM_WORD[15:0]};
                    issue_nxt.valid = 1'b1;
                    state_nxt = ST_FETCH;
                end
            end
            ST_WAIT: begin
                bubble_nxt = 1'b1;
                extra_nxt = extra_r - 2'h1;
                stall_nxt = (extra_r != 2'h1);
                if (extra_r == 2'h1) begin
                    state_nxt = ST_FETCH;
                end
            end
            default: begin
                state_nxt = ST_FETCH;
            end
        endcase
    end

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            state_r <= ST_FETCH;
            extra_r <= 2'h0;
            skip_pend_r <= 1'b0;
            issue_r <= '0;
            fields_r <= '0;
            stall_r <= 1'b0;
            bubble_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            extra_r <= extra_nxt;
            skip_pend_r <= skip_pend_nxt;
            issue_r <= issue_nxt;
            fields_r <= fields_nxt;
            stall_r <= stall_nxt;
            bubble_r <= bubble_nxt;
        end
    end

    assign ISSUE = issue_r;
    assign FIELDS = fields_r;
    assign FETCH_STALL = stall_r;
    assign BUBBLE = bubble_r;

    // lone second word issues as NOP
    property p_ext_nop;
        @(posedge CLOCK) disable iff (RST)
        (state_r == ST_FETCH && PM_VALID && is_ext) |=> (ISSUE.valid && ISSUE.is_nop);
    endproperty
    a_ext_nop: assert property (p_ext_nop) else $error("lone extension word not a nop");

    property p_two_cycles;
        @(posedge CLOCK) disable iff (RST)
        (ISSUE.valid && ISSUE.two_word && !ISSUE.is_nop) |-> ISSUE.cycles == CYC_TWO;
    endproperty
    a_two_cycles: assert property (p_two_cycles) else $error("two-word cycles wrong");

    // two-word needs a second fetch before issue
    property p_two_word_wait;
        @(posedge CLOCK) disable iff (RST)
        (state_r == ST_FETCH && PM_VALID && two_word && !skip_pend_r) |=> !ISSUE.valid;
    endproperty
    a_two_word_wait: assert property (p_two_word_wait) else $error("two-word issued early");

    property p_bubble_count;
        @(posedge CLOCK) disable iff (RST)
        (ISSUE.valid && ISSUE.cycles == CYC_THREE) |=> BUBBLE ##1 BUBBLE ##1 !BUBBLE;
    endproperty
    a_bubble_count: assert property (p_bubble_count) else $error("three-cycle bubbles wrong");

    property p_cond_taken;
        @(posedge CLOCK) disable iff (RST)
        (state_r == ST_FETCH && PM_VALID && is_change && COND_TRUE && !skip_pend_r)
        |=> ##1 BUBBLE ##1 !BUBBLE;
    endproperty
    a_cond_taken: assert property (p_cond_taken) else $error("taken branch bubble wrong");

    property p_skip_nop;
        @(posedge CLOCK) disable iff (RST)
        (skip_pend_r && state_r == ST_FETCH && PM_VALID && !two_word)
        |=> ISSUE.valid && ISSUE.is_nop;
    endproperty
    a_skip_nop: assert property (p_skip_nop) else $error("skipped word not a nop");

    property p_mul_pair;
        @(posedge CLOCK) disable iff (RST)
        (ISSUE.valid && ISSUE.mac) |-> (FIELDS.mul_a != FIELDS.mul_b)
        && (FIELDS.mul_a[3:2] == 2'h1) && (FIELDS.mul_b[3:2] == 2'h1);
    endproperty
    a_mul_pair: assert property (p_mul_pair) else $error("bad multiplicand pair");

    property p_class;
        @(posedge CLOCK) disable iff (RST)
        (ISSUE.valid && ISSUE.opcode >= OPC_DSP_LO && ISSUE.opcode <= OPC_DSP_HI)
        |-> ISSUE.cls == CLS_DSP;
    endproperty
    a_class: assert property (p_class) else $error("dsp class wrong");

    // lone extension word leaves no operands
    property p_ext_quiet;
        @(posedge CLOCK) disable iff (RST)
        (state_r == ST_FETCH && PM_VALID && is_ext && !skip_pend_r) |=> !(|FIELDS);
    endproperty
    a_ext_quiet: assert property (p_ext_quiet) else $error("extension nop has fields");

    // short fixed op: two cycles, fetch held
    property p_fixed_two;
        @(posedge CLOCK) disable iff (RST)
        (state_r == ST_FETCH && PM_VALID && is_fixed && !TBL_LONG && !skip_pend_r)
        |=> ISSUE.valid && ISSUE.cycles == CYC_TWO && FETCH_STALL;
    endproperty
    a_fixed_two: assert property (p_fixed_two) else $error("fixed op timing wrong");

    // double-word move: two cycles, one bubble
    property p_movd;
        @(posedge CLOCK) disable iff (RST)
        (state_r == ST_FETCH && PM_VALID && is_movd && !skip_pend_r)
        |=> (ISSUE.valid && ISSUE.cycles == CYC_TWO) ##1 BUBBLE;
    endproperty
    a_movd: assert property (p_movd) else $error("double move timing wrong");

    // write-back register fixed for multiply class
    property p_wb_dest;
        @(posedge CLOCK) disable iff (RST)
        (ISSUE.valid && ISSUE.mac && !ISSUE.is_nop) |-> FIELDS.dest_reg == W_ACC_WB;
    endproperty
    a_wb_dest: assert property (p_wb_dest) else $error("write-back register wrong");

    // a bubble never overlaps an issue
    property p_no_overlap;
        @(posedge CLOCK) disable iff (RST)
        BUBBLE |-> !ISSUE.valid;
    endproperty
    a_no_overlap: assert property (p_no_overlap) else $error("issue during bubble");
endmodule

// *** testbench/did_pmem_model.sv ***
/*
 Program memory model: presents queued words with their qualifiers.
 Assumes the decoder takes a word on an edge with PM_VALID high and no stall.
*/
`timescale 1ns/100ps
module did_pmem_model (
    input wire logic CLOCK,
    input wire logic RST,
    input wire logic FETCH_STALL,
    input wire logic HOLD_OFF,
    output logic [23:0] PM_WORD,
    output logic PM_VALID,
    output logic COND_TRUE,
    output logic SKIP_TAKEN,
    output logic TBL_LONG
);
    logic [26:0] q[$];

    task automatic push(input logic [23:0] w, input logic c, input logic s, input logic t);
        q.push_back({t, s, c, w});
    endtask

    always @(posedge CLOCK) begin
        if (RST) begin
            PM_VALID <= 1'b0;
            {TBL_LONG, SKIP_TAKEN, COND_TRUE, PM_WORD} <= 27'h0;
        end else if (!(PM_VALID && FETCH_STALL)) begin
            if (PM_VALID) begin
                void'(q.pop_front());
            end
            if (q.size() > 0 && !HOLD_OFF) begin
                PM_VALID <= 1'b1;
                {TBL_LONG, SKIP_TAKEN, COND_TRUE, PM_WORD} <= q[0];
            end else begin
                // idle lines toggle so stale values never look valid
                PM_VALID <= 1'b0;
                {TBL_LONG, SKIP_TAKEN, COND_TRUE, PM_WORD} <=
                    ~{TBL_LONG, SKIP_TAKEN, COND_TRUE, PM_WORD};
            end
        end
    end
endmodule

// *** testbench/tb.sv ***
/*
 Self-checking bench for the decode and issue-timing block.
 Assumes the program memory model in did_pmem_model and one 125 MHz clock.
*/
`timescale 1ns/100ps
module tb;
    import did_pkg::*;
    typedef struct {
        logic [7:0] opc;
        did_class_t cls;
        logic chk_cls;
        logic nop;
        logic two;
        logic [1:0] cyc;
        logic mac;
        logic [23:0] ext;
        int bub;
        logic loose;
    } did_exp_t;
    localparam logic [15:0] OPS [18] = '{
        {OPC_BRANCH_ALWAYS, 8'h00}, {OPC_BRANCH_ALWAYS, 8'h01}, 16'h3500, 16'h3504,
        {OPC_CALL_IND, 8'h00}, {OPC_CALL_IND, 8'h01}, {OPC_RETURN, 8'h00},
        {OPC_INT_RETURN, 8'h01}, {OPC_TBL_LO, 8'h00}, {OPC_TBL_HI, 8'h01},
        {OPC_MOVD, 8'h00}, 16'hA000, 16'hB000, 16'hB500, 16'hC300, 16'hC900,
        {OPC_NOP2, 8'h00}, 16'h4807};
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic hold_off = 1'b0;
    logic slow = 1'b0;
    logic [23:0] pm_word;
    logic pm_valid, cond_true, skip_taken, tbl_long, fetch_stall, bubble;
    did_issue_t issue;
    did_fields_t fields;
    did_exp_t exp_q[$];
    did_exp_t got;
    int n_fail = 0;
    int comparisons = 0;
    int seed = 94537;
    int bub_cnt = 0;
    int bub_exp = -1;

    always #4 clock = ~clock;
    always @(posedge clock) hold_off <= slow && ($random(seed) & 1);

    did_pmem_model u_pm (.CLOCK(clock), .RST(rst), .FETCH_STALL(fetch_stall),
        .HOLD_OFF(hold_off), .PM_WORD(pm_word), .PM_VALID(pm_valid),
        .COND_TRUE(cond_true), .SKIP_TAKEN(skip_taken), .TBL_LONG(tbl_long));
    did_decode uut (.CLOCK(clock), .RST(rst), .PM_WORD(pm_word), .PM_VALID(pm_valid),
        .COND_TRUE(cond_true), .SKIP_TAKEN(skip_taken), .TBL_LONG(tbl_long),
        .ISSUE(issue), .FIELDS(fields), .FETCH_STALL(fetch_stall), .BUBBLE(bubble));

    task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
        comparisons++;
        if (seen !== want) begin
            n_fail++;
            $display("MISMATCH t=%0t %s seen %0h want %0h", $time, what, seen, want);
        end
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic put(input logic [7:0] opc, input logic c, input logic s, input logic t);
        did_exp_t e;
        e = '{opc, CLS_WORD_BYTE, 1'b1, 1'b0, 1'b0, CYC_ONE, 1'b0, 24'h0, 0, 1'b0};
        // skips and table moves count as control flow in this core
        if (opc <= OPC_CTRL_HI) e.cls = CLS_CONTROL;
        else if (opc inside {OPC_SKIP_LO, OPC_SKIP_HI, OPC_TBL_LO, OPC_TBL_HI})
            e.cls = CLS_CONTROL;
        else if (opc >= OPC_BIT_LO && opc <= OPC_BIT_HI) e.cls = CLS_BIT;
        else if (opc >= OPC_LIT_LO && opc <= OPC_LIT_HI) e.cls = CLS_LITERAL;
        else if (opc >= OPC_DSP_LO && opc <= OPC_DSP_HI) e.cls = CLS_DSP;
        e.mac = opc >= OPC_DSP_LO && opc <= OPC_MAC_HI;
        e.nop = opc == OPC_NOP2;
        if (opc inside {OPC_BRANCH_ALWAYS, OPC_CALL_IND, OPC_RETURN, OPC_INT_RETURN,
                OPC_TBL_LO, OPC_TBL_HI})
            e.cyc = t ? CYC_THREE : CYC_TWO;
        else if (opc >= OPC_BRANCH_COND_LO && opc <= OPC_BRANCH_COND_HI && c)
            e.cyc = CYC_TWO;
        else if (opc == OPC_MOVD || (opc inside {OPC_SKIP_LO, OPC_SKIP_HI} && s))
            e.cyc = CYC_TWO;
        e.bub = int'(e.cyc) - 1;
        // skip penalty shows as a victim no-op, not a bubble
        if (opc inside {OPC_SKIP_LO, OPC_SKIP_HI}) e.bub = 0;
        u_pm.push({opc, 16'($random(seed))}, c, s, t);
        exp_q.push_back(e);
    endtask

    task automatic put2(input logic [7:0] opc, input logic loose);
        did_exp_t e;
        logic [23:0] x;
        x = {8'h00, 16'($random(seed))};
        e = '{opc, CLS_CONTROL, 1'b1, loose, 1'b1, CYC_TWO, 1'b0, x, 0, loose};
        u_pm.push({opc, 16'($random(seed))}, 1'b0, 1'b0, 1'b0);
        u_pm.push(x, 1'b1, 1'b1, 1'b1);
        exp_q.push_back(e);
    endtask

    task automatic prog();
        logic [31:0] r;
        foreach (OPS[i]) put(OPS[i][15:8], OPS[i][2], OPS[i][1], OPS[i][0]);
        put(OPC_SKIP_LO, 1'b0, 1'b0, 1'b0);
        put(8'h48, 1'b0, 1'b0, 1'b0);
        put(OPC_SKIP_HI, 1'b0, 1'b1, 1'b0);
        put(8'h50, 1'b0, 1'b0, 1'b0);
        exp_q[$] = '{8'h50, CLS_CONTROL, 1'b0, 1'b1, 1'b0, 2'h0, 1'b0, 24'h0, 0, 1'b1};
        put(OPC_SKIP_LO, 1'b0, 1'b1, 1'b0);
        exp_q[$].cyc = 2'h0;
        put2(OPC_JUMP_ABS, 1'b1);
        put2(OPC_JUMP_ABS, 1'b0);
        put2(OPC_CALL_ABS, 1'b0);
        put2(OPC_DO_LOOP, 1'b0);
        for (int i = 0; i < 8; i++) begin
            r = $random(seed);
            put(8'h40 | {2'b00, r[13:8]}, r[0], r[1], r[2]);
        end
    endtask

    always @(posedge clock) begin
        if (!rst) begin
            if (issue.valid === 1'b1) begin
                if (bub_exp >= 0) check(bub_cnt, bub_exp, "bubbles");
                bub_cnt = 0;
                if (exp_q.size() == 0) begin
                    n_fail++;
                    $display("MISMATCH t=%0t unexpected issue", $time);
                end else begin
                    got = exp_q.pop_front();
                    bub_exp = got.bub;
                    check(issue.is_nop, got.nop, "no-op");
                    if (!got.loose) begin
                        check(issue.opcode, got.opc, "opcode");
                        if (got.chk_cls) check(issue.cls, got.cls, "class");
                        check(issue.two_word, got.two, "two word");
                        check(issue.mac, got.mac, "mac flag");
                        if (got.cyc != 2'h0) check(issue.cycles, got.cyc, "cycles");
                        if (got.two) check(issue.ext_word, got.ext, "extension");
                        if (got.nop) check(|fields, 1'b0, "nop fields");
                        if (got.mac) check(fields.dest_reg, W_ACC_WB, "writeback reg");
                    end
                end
            end
            if (bubble === 1'b1) bub_cnt++;
        end
    end

    initial begin
        repeat (20000) @(posedge clock);
        n_fail++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        results();
    end

    initial begin
        prog();
        repeat (16) @(posedge clock);
        check(|issue, 1'b0, "issue in reset");
        check(|fields, 1'b0, "fields in reset");
        check({fetch_stall, bubble}, 2'b00, "stall in reset");
        rst <= 1'b0;
        for (int pass = 0; pass < 2; pass++) begin
            for (int i = 0; i < 3000 && exp_q.size() != 0; i++) @(posedge clock);
            repeat (8) @(posedge clock);
            if (pass == 0) begin
                slow <= 1'b1;
                prog();
            end
        end
        if (bub_exp >= 0) check(bub_cnt, bub_exp, "final bubbles");
        check(exp_q.size(), 0, "issues outstanding");
        results();
    end
endmodule
